// file: src/cpu_debug_status.sv
// Capability register and debug exception status and control register
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Capability register is read-only; no bit can be changed.
// - Capability bits 31:9, 7 and 4:0 read zero.
// - Capability bit 8 reports trace hardware presence, zero by default.
// - Capability bit 6 always reads one: interrupt controller mode supported.
// - Capability bit 5 always reads one: vectored interrupts supported.
// - Info fields refresh on debug exception and exception in debug state.
// - Outside debug state only state flag and revision are valid.
// - Cause flags update on debug exceptions and exceptions in debug state.
// - Nested cause written only on exceptions in debug state.
// - Bus clock and low-power flags captured on debug exception only.
// - Bit 31 records delay slot on both exception kinds.
// - Bit 30 reads one while in debug state.
// - Bit 29 reads one when no debug segment exists.
// - Fetch bus-error pending sets on error or write one, clears when taken.
// - Inhibit sets on debug entry, clears on return, defers imprecise errors.
// - Bit 25 tells whether the cycle counter runs in debug state.
// - Single-step control bit set arms a single-step exception.
module cpu_debug_status
	import cpu_dbg_pkg::*;
#(
	parameter logic       TRACE_PRESENT = TRACE_DEFAULT,
	parameter logic       NO_DEBUG_SEG  = NOSEG_DEFAULT,
	parameter logic [2:0] SPEC_REVISION = REV_DEFAULT
) (
	// Clock and reset
	input  wire logic     ref_clk,
	input  wire logic     nrst,
	// Coprocessor register moves
	input  wire cp0_req_s cp0_req,
	output logic [31:0]   rd_data,
	output logic          rd_valid,
	// Exception events from the pipeline
	input  wire logic     dbg_exc_taken,
	input  wire logic     exc_in_dbg_taken,
	input  wire cause_s   dbg_cause,
	input  wire logic     in_delay_slot,
	input  wire logic [4:0] nested_code,
	input  wire logic     bus_clk_running,
	input  wire logic     low_power,
	input  wire logic     debug_return_instr,
	// Bus error events
	input  wire logic     fetch_bus_err,
	input  wire logic     fetch_bus_err_taken,
	input  wire logic     data_bus_err,
	input  wire logic     data_bus_err_taken,
	// Status towards the core
	output logic          in_debug_state,
	output logic          single_step_armed,
	output logic          fetch_bus_err_req,
	output logic          data_bus_err_req,
	output logic          imprecise_err_inhibit,
	output logic          counter_runs_in_debug,
	output logic          dseg_to_main_mem
);

	typedef struct packed {
		logic [31:0] rd_data;
		logic        rd_valid;
		logic        in_debug_state;
		logic        single_step_enable;
		logic        single_step_armed;
		logic        fetch_bus_err_pending;
		logic        data_bus_err_pending;
		logic        fetch_req;
		logic        data_req;
		logic        imprecise_err_inhibit;
		logic        counter_runs_in_debug;
		logic        dseg_to_main_mem;
	} state_s;

	state_s      st_r;
	state_s      st_nxt;
	logic [1:0]  rst_sync_r;
	logic        rst_n;
	capture_s    captured;
	reg_target_e rd_tgt;
	reg_target_e wr_tgt;
	logic        dbg_wr;
	logic        any_entry;
	logic [31:0] cap_word;
	logic [31:0] dbg_word;

	// Reset is asserted at once and released two edges later
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign rst_n = rst_sync_r[1];

	debug_cause_capture u_capture (
		.clk              (ref_clk),
		.rst_n            (rst_n),
		.dbg_exc_taken    (dbg_exc_taken),
		.exc_in_dbg_taken (exc_in_dbg_taken),
		.cause_in         (dbg_cause),
		.in_delay_slot    (in_delay_slot),
		.nested_code      (nested_code),
		.bus_clk_running  (bus_clk_running),
		.low_power        (low_power),
		.captured         (captured)
	);

	assign rd_tgt    = decode_target(cp0_req.num, cp0_req.sel);
	assign wr_tgt    = decode_target(cp0_req.num, cp0_req.sel);
	assign any_entry = dbg_exc_taken | exc_in_dbg_taken;
	// Writes from normal state are dropped to keep the core defined
	assign dbg_wr    = cp0_req.wr && wr_tgt == TGT_DBG
		&& st_r.in_debug_state;

	// Capability word: only fixed capabilities, everything else zero
	always_comb begin
		cap_word                = 32'h0000_0000;
		cap_word[CAP_TRACE_BIT] = TRACE_PRESENT;
		cap_word[CAP_EIC_BIT]   = CAP_EIC_VAL;
		cap_word[CAP_VECT_BIT]  = CAP_VECT_VAL;
	end

	// Debug word; fields other than state and revision carry stale data
	// when read from normal state, which software must not rely on
	always_comb begin
		dbg_word                  = 32'h0000_0000;
		dbg_word[DBG_SLOT_BIT]    = captured.delay_slot_flag;
		dbg_word[DBG_STATE_BIT]   = st_r.in_debug_state;
		dbg_word[DBG_NOSEG_BIT]   = NO_DEBUG_SEG;
		dbg_word[DBG_DMAP_BIT]    = st_r.dseg_to_main_mem;
		dbg_word[DBG_LOWPWR_BIT]  = captured.low_power_at_entry;
		dbg_word[DBG_BUSCLK_BIT]  = captured.bus_clk_running;
		dbg_word[DBG_CNTRUN_BIT]  = st_r.counter_runs_in_debug;
		dbg_word[DBG_FPEND_BIT]   = st_r.fetch_bus_err_pending;
		dbg_word[DBG_DPEND_BIT]   = st_r.data_bus_err_pending;
		dbg_word[DBG_INHIBIT_BIT] = st_r.imprecise_err_inhibit;
		dbg_word[DBG_REV_LSB +: 3]  = SPEC_REVISION;
		dbg_word[DBG_NEST_LSB +: 5] = captured.nested_exc_cause;
		dbg_word[DBG_STEP_BIT]    = st_r.single_step_enable;
		dbg_word[DBG_CAUSE_LSB +: 6] = captured.cause;
	end

	always_comb begin
		st_nxt = st_r;

		// Read path: one cycle from request to data
		st_nxt.rd_valid = cp0_req.rd;
		if (cp0_req.rd) begin
			case (rd_tgt)
				TGT_CAP: st_nxt.rd_data = cap_word;
				TGT_DBG: st_nxt.rd_data = dbg_word;
				TGT_NONE: st_nxt.rd_data = 32'h0000_0000;
				default: st_nxt.rd_data = 32'h0000_0000;
			endcase
		end
		// A write to the capability register has no target: ignored

		// Debug state: return leaves it, a debug exception enters it
		if (debug_return_instr)
			st_nxt.in_debug_state = 1'b0;
		if (dbg_exc_taken)
			st_nxt.in_debug_state = 1'b1;

		// Software-writable control fields
		if (dbg_wr) begin
			st_nxt.dseg_to_main_mem      = cp0_req.wdata[DBG_DMAP_BIT];
			st_nxt.counter_runs_in_debug = cp0_req.wdata[DBG_CNTRUN_BIT];
			st_nxt.single_step_enable    = cp0_req.wdata[DBG_STEP_BIT];
			st_nxt.imprecise_err_inhibit = cp0_req.wdata[DBG_INHIBIT_BIT];
		end

		// Inhibit: entry wins over a return or write in the same cycle
		if (debug_return_instr)
			st_nxt.imprecise_err_inhibit = 1'b0;
		if (any_entry)
			st_nxt.imprecise_err_inhibit = 1'b1;

		// Pending bits: the set wins over the clear of the taken exception
		if (fetch_bus_err_taken)
			st_nxt.fetch_bus_err_pending = 1'b0;
		if (fetch_bus_err || (dbg_wr && cp0_req.wdata[DBG_FPEND_BIT]))
			st_nxt.fetch_bus_err_pending = 1'b1;
		if (data_bus_err_taken)
			st_nxt.data_bus_err_pending = 1'b0;
		if (data_bus_err || (dbg_wr && cp0_req.wdata[DBG_DPEND_BIT]))
			st_nxt.data_bus_err_pending = 1'b1;

		// Imprecise errors are requested only while not inhibited
		st_nxt.fetch_req = st_nxt.fetch_bus_err_pending
			& ~st_nxt.imprecise_err_inhibit;
		st_nxt.data_req = st_nxt.data_bus_err_pending
			& ~st_nxt.imprecise_err_inhibit;

		// Single step acts on normal-state code after the return
		st_nxt.single_step_armed = st_nxt.single_step_enable
			& ~st_nxt.in_debug_state;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r                       <= '0;
			st_r.in_debug_state        <= DBG_STATE_RST;
			st_r.single_step_enable    <= STEP_RST;
			st_r.fetch_bus_err_pending <= PEND_RST;
			st_r.data_bus_err_pending  <= PEND_RST;
			st_r.imprecise_err_inhibit <= INHIBIT_RST;
			st_r.counter_runs_in_debug <= CNTRUN_RST;
			st_r.dseg_to_main_mem      <= DMAP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data               = st_r.rd_data;
	assign rd_valid              = st_r.rd_valid;
	assign in_debug_state        = st_r.in_debug_state;
	assign single_step_armed     = st_r.single_step_armed;
	assign fetch_bus_err_req     = st_r.fetch_req;
	assign data_bus_err_req      = st_r.data_req;
	assign imprecise_err_inhibit = st_r.imprecise_err_inhibit;
	assign counter_runs_in_debug = st_r.counter_runs_in_debug;
	assign dseg_to_main_mem      = st_r.dseg_to_main_mem;

endmodule : cpu_debug_status
`default_nettype wire

// file: shared/cpu_dbg_pkg.sv
// Shared constants and types for the capability and debug status registers
`default_nettype none
package cpu_dbg_pkg;

	// Coprocessor register numbers and selects
	localparam logic [4:0] CAP_REG_NUM = 5'h10;
	localparam logic [2:0] CAP_REG_SEL = 3'h3;
	localparam logic [4:0] DBG_REG_NUM = 5'h17;
	localparam logic [2:0] DBG_REG_SEL = 3'h0;

	// Capability register field positions
	localparam int unsigned CAP_TRACE_BIT = 8;
	localparam int unsigned CAP_EIC_BIT   = 6;
	localparam int unsigned CAP_VECT_BIT  = 5;

	// Debug register field positions
	localparam int unsigned DBG_SLOT_BIT    = 31;
	localparam int unsigned DBG_STATE_BIT   = 30;
	localparam int unsigned DBG_NOSEG_BIT   = 29;
	localparam int unsigned DBG_DMAP_BIT    = 28;
	localparam int unsigned DBG_LOWPWR_BIT  = 27;
	localparam int unsigned DBG_BUSCLK_BIT  = 26;
	localparam int unsigned DBG_CNTRUN_BIT  = 25;
	localparam int unsigned DBG_FPEND_BIT   = 24;
	localparam int unsigned DBG_DPEND_BIT   = 21;
	localparam int unsigned DBG_INHIBIT_BIT = 20;
	localparam int unsigned DBG_REV_LSB     = 15;
	localparam int unsigned DBG_NEST_LSB    = 10;
	localparam int unsigned DBG_STEP_BIT    = 8;
	localparam int unsigned DBG_CAUSE_LSB   = 0;

	// Reset and fixed values
	localparam logic       CAP_EIC_VAL   = 1'b1;
	localparam logic       CAP_VECT_VAL  = 1'b1;
	localparam logic       CNTRUN_RST    = 1'b1;
	localparam logic       DMAP_RST      = 1'b0;
	localparam logic       STEP_RST      = 1'b0;
	localparam logic       INHIBIT_RST   = 1'b0;
	localparam logic       PEND_RST      = 1'b0;
	localparam logic       DBG_STATE_RST = 1'b0;
	localparam logic [2:0] REV_DEFAULT   = 3'h2;
	localparam logic       NOSEG_DEFAULT = 1'b0;
	localparam logic       TRACE_DEFAULT = 1'b0;

	typedef enum logic [1:0] {TGT_NONE, TGT_CAP, TGT_DBG} reg_target_e;

	// Cause flags in the order of debug register bits 5 down to 0
	typedef struct packed {
		logic debug_irq_hit;
		logic instr_break_hit;
		logic store_data_break_hit;
		logic load_data_break_hit;
		logic sw_breakpoint_hit;
		logic single_step_hit;
	} cause_s;

	typedef struct packed {
		logic       delay_slot_flag;
		logic       low_power_at_entry;
		logic       bus_clk_running;
		logic [4:0] nested_exc_cause;
		cause_s     cause;
	} capture_s;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  num;
		logic [2:0]  sel;
		logic [31:0] wdata;
	} cp0_req_s;

	function automatic reg_target_e decode_target(input logic [4:0] num,
		input logic [2:0] sel);
		if (num == CAP_REG_NUM && sel == CAP_REG_SEL)
			return TGT_CAP;
		else if (num == DBG_REG_NUM && sel == DBG_REG_SEL)
			return TGT_DBG;
		else
			return TGT_NONE;
	endfunction : decode_target

endpackage : cpu_dbg_pkg
`default_nettype wire

// file: src/debug_cause_capture.sv
// Capture of debug exception cause, delay slot and entry conditions
`timescale 1ns/1ps
`default_nettype none
module debug_cause_capture
	import cpu_dbg_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     rst_n,
	// Exception events
	input  wire logic     dbg_exc_taken,
	input  wire logic     exc_in_dbg_taken,
	input  wire cause_s   cause_in,
	input  wire logic     in_delay_slot,
	input  wire logic [4:0] nested_code,
	input  wire logic     bus_clk_running,
	input  wire logic     low_power,
	// Captured fields
	output var capture_s  captured
);

	capture_s cap_r;
	capture_s cap_nxt;

	always_comb begin
		cap_nxt = cap_r;
		if (exc_in_dbg_taken) begin
			cap_nxt.delay_slot_flag  = in_delay_slot;
			cap_nxt.nested_exc_cause = nested_code;
			cap_nxt.cause            = '0;
		end else if (dbg_exc_taken) begin
			// Nested cause is left as it was: its value is undefined here
			cap_nxt.delay_slot_flag    = in_delay_slot;
			cap_nxt.cause              = cause_in;
			cap_nxt.bus_clk_running    = bus_clk_running;
			cap_nxt.low_power_at_entry = low_power;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cap_r <= '0;
		else
			cap_r <= cap_nxt;
	end

	assign captured = cap_r;

endmodule : debug_cause_capture
`default_nettype wire

// file: test/cpu_debug_status_props.sv
// Assertions on the capability and debug status register block
`timescale 1ns/1ps
`default_nettype none
module cpu_debug_status_props
	import cpu_dbg_pkg::*;
#(
	parameter logic       TRACE_PRESENT = 1'b0,
	parameter logic       NO_DEBUG_SEG  = 1'b0,
	parameter logic [2:0] SPEC_REVISION = 3'h2
) (
	// Clock, reset and register moves
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire cp0_req_s    cp0_req,
	input wire logic [31:0] rd_data,
	input wire logic        rd_valid,
	// Exception and error events
	input wire logic        dbg_exc_taken,
	input wire logic        exc_in_dbg_taken,
	input wire cause_s      dbg_cause,
	input wire logic        in_delay_slot,
	input wire logic [4:0]  nested_code,
	input wire logic        bus_clk_running,
	input wire logic        low_power,
	input wire logic        debug_return_instr,
	input wire logic        fetch_bus_err,
	input wire logic        fetch_bus_err_taken,
	// Status outputs
	input wire logic        in_debug_state,
	input wire logic        single_step_armed,
	input wire logic        fetch_bus_err_req,
	input wire logic        data_bus_err_req,
	input wire logic        imprecise_err_inhibit
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic rdc, rdd, quiet;
	assign rdc = cp0_req.rd && cp0_req.num == CAP_REG_NUM
		&& cp0_req.sel == CAP_REG_SEL;
	assign rdd = cp0_req.rd && cp0_req.num == DBG_REG_NUM
		&& cp0_req.sel == DBG_REG_SEL;
	// No exception, return or write alongside, so the read shows settled fields
	assign quiet = !dbg_exc_taken && !exc_in_dbg_taken
		&& !debug_return_instr && !cp0_req.wr;

	a_cap_value: assert property (rdc |=> rd_valid
		&& rd_data == {23'h0, TRACE_PRESENT, 8'h60})
		else $error("capability read value wrong");
	a_entry_state: assert property (dbg_exc_taken |=>
		in_debug_state && imprecise_err_inhibit)
		else $error("debug entry not recorded");
	a_exit_state: assert property (debug_return_instr
		&& !dbg_exc_taken && !exc_in_dbg_taken && !cp0_req.wr
		|=> !in_debug_state && !imprecise_err_inhibit)
		else $error("debug return not recorded");
	a_cause_load: assert property (dbg_exc_taken ##1 quiet
		##1 (rdd && quiet) |=> rd_data[5:0] == $past(dbg_cause, 3)
		&& rd_data[31] == $past(in_delay_slot, 3)
		&& rd_data[27] == $past(low_power, 3)
		&& rd_data[26] == $past(bus_clk_running, 3))
		else $error("debug cause fields wrong");
	a_nested_load: assert property (exc_in_dbg_taken
		&& in_debug_state ##1 quiet ##1 (rdd && quiet) |=>
		rd_data[14:10] == $past(nested_code, 3) && rd_data[5:0] == 6'h0)
		else $error("nested cause fields wrong");
	a_fixed_fields: assert property (rdd && quiet |=>
		rd_data[29] == NO_DEBUG_SEG && rd_data[17:15] == SPEC_REVISION
		&& rd_data[30] == $past(in_debug_state))
		else $error("debug fixed fields wrong");
	a_fetch_set: assert property (fetch_bus_err
		&& !in_debug_state && !dbg_exc_taken |=> fetch_bus_err_req)
		else $error("fetch error not pending");
	a_fetch_clear: assert property (fetch_bus_err_taken
		&& !fetch_bus_err && !cp0_req.wr |=> !fetch_bus_err_req)
		else $error("fetch error not cleared");
	a_inhibit_defer: assert property (imprecise_err_inhibit |->
		!fetch_bus_err_req && !data_bus_err_req)
		else $error("error request while inhibited");
	a_step_armed: assert property (single_step_armed |->
		!in_debug_state)
		else $error("single step armed in debug state");

	c_entry: cover property (dbg_exc_taken);
	c_nested: cover property (exc_in_dbg_taken && in_debug_state);
	c_fetch_req: cover property (fetch_bus_err_req);
endmodule : cpu_debug_status_props
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the capability and debug status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cpu_dbg_pkg::*;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	cp0_req_s    req = '0;
	cause_s      cause = '0;
	logic [6:0]  ev = '0;
	logic        slot = 1'b0, bc = 1'b0, lp = 1'b0;
	logic [4:0]  code = 5'h0, n;
	logic [2:0]  s;
	logic [31:0] rd_data, d, w;
	logic        rd_valid, in_dbg, armed, freq, dreq, inh, cnt, dmap;
	integer      seed = 32'ha42c2a5b;
	int          err_count = 0, total_checks = 0;

	cpu_debug_status cpu_debug_status_i (
		.ref_clk, .nrst, .cp0_req(req), .rd_data, .rd_valid,
		.dbg_exc_taken(ev[0]), .exc_in_dbg_taken(ev[1]),
		.dbg_cause(cause), .in_delay_slot(slot), .nested_code(code),
		.bus_clk_running(bc), .low_power(lp),
		.debug_return_instr(ev[2]), .fetch_bus_err(ev[3]),
		.fetch_bus_err_taken(ev[4]), .data_bus_err(ev[5]),
		.data_bus_err_taken(ev[6]), .in_debug_state(in_dbg),
		.single_step_armed(armed), .fetch_bus_err_req(freq),
		.data_bus_err_req(dreq), .imprecise_err_inhibit(inh),
		.counter_runs_in_debug(cnt), .dseg_to_main_mem(dmap));

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic chkf(input logic g, e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chkf

	// Events last one cycle with an idle cycle after, never back to back
	task automatic fire(input logic [6:0] e);
		@(negedge ref_clk);
		ev = e;
		@(negedge ref_clk);
		ev = '0;
	endtask : fire

	task automatic acc(input logic r, input logic [4:0] an,
		input logic [2:0] as, input logic [31:0] wd);
		@(negedge ref_clk);
		req = '{rd: r, wr: !r, num: an, sel: as, wdata: wd};
		@(negedge ref_clk);
		req = '0;
		if (r)
			chkf(rd_valid, 1'b1);
		d = rd_data;
	endtask : acc

	function automatic logic [31:0] exp_cap(input logic [4:0] an,
		input logic [2:0] as);
		if (an == CAP_REG_NUM && as == CAP_REG_SEL)
			return 32'h0000_0060;
		return 32'h0;
	endfunction : exp_cap

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	initial begin
		#(25 * 5000);
		err_count++;
		print_verdict;
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		// Outside debug state only the state flag and revision are defined
		acc(1'b1, DBG_REG_NUM, DBG_REG_SEL, 32'h0);
		chk(d & 32'h4003_8000, 32'h0001_0000);
		chkf(cnt, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			w = $random(seed);
			n = (i < 6) ? CAP_REG_NUM : w[4:0];
			s = (i < 6) ? CAP_REG_SEL : w[7:5];
			if (n == DBG_REG_NUM)
				n = 5'h0;
			acc(1'b0, n, s, w);
			acc(1'b1, n, s, 32'h0);
			chk(d, exp_cap(n, s));
		end
		$display("test capability done");
		for (int k = 0; k < 6; k++) begin
			w = $random(seed);
			{slot, lp, bc, code} = w[7:0];
			cause = cause_s'(6'h1 << k);
			fire(7'h01);
			chkf(inh, 1'b1);
			acc(1'b1, DBG_REG_NUM, DBG_REG_SEL, 32'h0);
			chk(d & 32'hcc00_003f, {slot, 3'h4, lp, bc, 20'h0, cause});
			w = $random(seed);
			{slot, code} = w[5:0];
			fire(7'h02);
			acc(1'b1, DBG_REG_NUM, DBG_REG_SEL, 32'h0);
			chk(d & 32'hc000_7c3f, {slot, 16'h8000, code, 10'h0});
			fire(7'h04);
			chkf(in_dbg | inh, 1'b0);
		end
		$display("test causes done");
		fire(7'h01);
		acc(1'b0, DBG_REG_NUM, DBG_REG_SEL, 32'h1000_0100);
		chkf(cnt, 1'b0);
		chkf(dmap, 1'b1);
		fire(7'h04);
		chkf(armed, 1'b1);
		fire(7'h01);
		chkf(armed, 1'b0);
		acc(1'b0, DBG_REG_NUM, DBG_REG_SEL, 32'h0200_0000);
		chkf(cnt, 1'b1);
		chkf(dmap, 1'b0);
		fire(7'h04);
		chkf(armed, 1'b0);
		$display("test step done");
		fire(7'h28);
		chkf(freq & dreq, 1'b1);
		fire(7'h01);
		chkf(freq | dreq, 1'b0);
		fire(7'h04);
		chkf(freq & dreq, 1'b1);
		fire(7'h50);
		chkf(freq | dreq, 1'b0);
		// Software sets the fetch pending bit; it waits for the return
		fire(7'h01);
		acc(1'b0, DBG_REG_NUM, DBG_REG_SEL, 32'h0310_0000);
		chkf(freq, 1'b0);
		fire(7'h04);
		chk({30'h0, freq, dreq}, 32'h0000_0002);
		fire(7'h10);
		chkf(freq, 1'b0);
		$display("test bus errors done");
		print_verdict;
	end
endmodule : testbench

bind cpu_debug_status cpu_debug_status_props #(
	.TRACE_PRESENT(TRACE_PRESENT), .NO_DEBUG_SEG(NO_DEBUG_SEG),
	.SPEC_REVISION(SPEC_REVISION)) props_i (
	.ref_clk, .nrst, .cp0_req, .rd_data, .rd_valid, .dbg_exc_taken,
	.exc_in_dbg_taken, .dbg_cause, .in_delay_slot, .nested_code,
	.bus_clk_running, .low_power, .debug_return_instr, .fetch_bus_err,
	.fetch_bus_err_taken, .in_debug_state, .single_step_armed,
	.fetch_bus_err_req, .data_bus_err_req, .imprecise_err_inhibit);
`default_nettype wire
